// file: src/dmx_exec.sv
// execution of file move, indirect load and bank-select literal load
`timescale 1ns/1ps
`include "dmx_consts.svh"
module dmx_exec
  import dmx_pkg::*;
#(
  parameter int DATA_W = `DMX_DATA_W,
  parameter int PTR_W  = `DMX_PTR_W
) (
  input  wire logic                    clk,
  input  wire logic                    reset_n,
  input  wire logic                    op_valid,
  input  wire dmx_op_type              op_kind,
  input  wire logic [`DMX_FADDR_W-1:0] op_faddr,
  input  wire logic                    op_dest,
  input  wire logic                    op_ptr_sel,
  input  wire logic                    op_rel,
  input  wire logic [1:0]              pointer_update_mode,
  input  wire logic [`DMX_OFS_W-1:0]   op_offset,
  input  wire logic [`DMX_BANK_W-1:0]  op_literal,
  output logic                         op_ready,
  output logic                         mem_rd,
  output logic                         mem_wr,
  output logic [PTR_W-1:0]             mem_addr,
  output logic [DATA_W-1:0]            mem_wdata,
  input  wire logic [DATA_W-1:0]       mem_rdata,
  input  wire logic                    mem_rvalid,
  output logic [DATA_W-1:0]            acc_w,
  output logic                         zero_flag,
  output logic [`DMX_BANK_W-1:0]       bank_select_reg,
  output logic [PTR_W-1:0]             indirect_pointer0,
  output logic [PTR_W-1:0]             indirect_pointer1,
  output logic                         op_done
);

  // sign-extend the relative offset to pointer width
  function automatic logic [PTR_W-1:0] sext_ofs(input logic [`DMX_OFS_W-1:0] o);
    sext_ofs = {{(PTR_W-`DMX_OFS_W){o[`DMX_OFS_W-1]}}, o};
  endfunction : sext_ofs

  // effective address for one indirect access
  function automatic logic [PTR_W-1:0] eff_addr(input logic [PTR_W-1:0] p, input logic rel,
                                                input logic [1:0] md, input logic [`DMX_OFS_W-1:0] o);
    if (rel) begin
      eff_addr = p + sext_ofs(o);
    end else begin
      case (md)
        `DMX_MODE_PREINC: begin
          eff_addr = p + PTR_W'(1);
        end
        `DMX_MODE_PREDEC: begin
          eff_addr = p - PTR_W'(1);
        end
        default: begin
          // post modes address the pointer as it stands before the step
          eff_addr = p;
        end
      endcase
    end
  endfunction : eff_addr

  // pointer value left behind by one indirect access
  function automatic logic [PTR_W-1:0] ptr_after(input logic [PTR_W-1:0] p, input logic rel,
                                                 input logic [1:0] md);
    if (rel) begin
      ptr_after = p;
    end else if (md == `DMX_MODE_PREINC || md == `DMX_MODE_POSTINC) begin
      ptr_after = p + PTR_W'(1);
    end else begin
      ptr_after = p - PTR_W'(1);
    end
  endfunction : ptr_after

  // an alias location resolves to the pointer it names
  function automatic logic [PTR_W-1:0] alias_ptr(input logic [`DMX_FADDR_W-1:0] fa,
                                                 input logic [PTR_W-1:0] p0, input logic [PTR_W-1:0] p1);
    if (fa == `DMX_ALIAS1_ADDR) begin
      alias_ptr = p1;
    end else begin
      alias_ptr = p0;
    end
  endfunction : alias_ptr

  dmx_state_type             state_r, state_nxt;
  logic [DATA_W-1:0]         acc_r, acc_nxt;
  logic                      zero_r, zero_nxt;
  logic [`DMX_BANK_W-1:0]    bank_r, bank_nxt;
  logic [PTR_W-1:0]          ptr0_r, ptr0_nxt;
  logic [PTR_W-1:0]          ptr1_r, ptr1_nxt;
  logic                      dest_r, dest_nxt;
  logic                      load_r, load_nxt;
  logic [PTR_W-1:0]          addr_r, addr_nxt;
  logic                      done_r, done_nxt;
  logic                      rd_r, rd_nxt;
  logic                      wr_r, wr_nxt;
  logic [DATA_W-1:0]         wdata_r, wdata_nxt;
  logic [PTR_W-1:0]          sel_ptr;
  logic                      is_alias;
  logic                      take;
  logic                      mv_go;
  logic                      ind_go;
  logic                      bank_go;
  logic                      fin;

  assign sel_ptr  = op_ptr_sel ? ptr1_r : ptr0_r;
  // alias locations are pure address redirection; nothing is stored for them
  assign is_alias  = (op_faddr == `DMX_ALIAS0_ADDR) || (op_faddr == `DMX_ALIAS1_ADDR);

  // one issue strobe per kind; only the idle state accepts a request
  assign take    = op_valid && (state_r == DMX_IDLE);
  assign mv_go   = take && (op_kind == DMX_OP_FILE_MOVE);
  assign ind_go  = take && (op_kind == DMX_OP_INDIRECT_LOAD);
  assign bank_go = take && (op_kind == DMX_OP_BANK_LOAD);
  // read data is only taken while a read is outstanding
  assign fin     = mem_rvalid && (state_r == DMX_WAIT);

  // sequencing: a memory op parks in the wait state until its read data returns
  always_comb begin
    state_nxt = state_r;
    dest_nxt  = dest_r;
    load_nxt  = load_r;
    done_nxt  = 1'b0;
    case (state_r)
      DMX_IDLE: begin
        if (op_valid) begin
          case (op_kind)
            DMX_OP_FILE_MOVE, DMX_OP_INDIRECT_LOAD: begin
              dest_nxt  = (op_kind == DMX_OP_FILE_MOVE) && op_dest;
              load_nxt  = (op_kind == DMX_OP_INDIRECT_LOAD);
              state_nxt = DMX_WAIT;
            end
            DMX_OP_BANK_LOAD: begin
              done_nxt = 1'b1;
            end
            default: begin
              // an empty op finishes nothing, so it raises no done pulse
              done_nxt = 1'b0;
            end
          endcase
        end
      end
      DMX_WAIT: begin
        // rvalid outside the wait state is ignored; there is no read to pair it with
        if (mem_rvalid) begin
          done_nxt  = 1'b1;
          state_nxt = DMX_IDLE;
        end
      end
      default: begin
        state_nxt = DMX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    // reset leaves the block idle and ready for a request
    if (!reset_n) begin
      state_r <= DMX_IDLE;
      dest_r  <= 1'b0;
      load_r  <= 1'b0;
      done_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      dest_r  <= dest_nxt;
      load_r  <= load_nxt;
      done_r  <= done_nxt;
    end
  end

  // read request: the address is latched at issue and held until the next request
  always_comb begin
    addr_nxt = addr_r;
    rd_nxt   = 1'b0;
    if (mv_go) begin
      // an alias location has no storage, so the read goes to the pointer it names
      addr_nxt = is_alias ? alias_ptr(op_faddr, ptr0_r, ptr1_r) : PTR_W'(op_faddr);
      rd_nxt   = 1'b1;
    end
    if (ind_go) begin
      addr_nxt = eff_addr(sel_ptr, op_rel, pointer_update_mode, op_offset);
      rd_nxt   = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_r <= `DMX_PTR_RESET;
      rd_r   <= 1'b0;
    end else begin
      addr_r <= addr_nxt;
      rd_r   <= rd_nxt;
    end
  end

  // write-back of a file move to itself, issued with the done pulse
  always_comb begin
    wr_nxt    = 1'b0;
    wdata_nxt = wdata_r;
    if (fin && dest_r && !load_r) begin
      wr_nxt    = 1'b1;
      wdata_nxt = mem_rdata;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_r    <= 1'b0;
      wdata_r <= `DMX_W_RESET;
    end else begin
      wr_r    <= wr_nxt;
      wdata_r <= wdata_nxt;
    end
  end

  // accumulator and zero flag only change on returned read data
  always_comb begin
    acc_nxt  = acc_r;
    zero_nxt = zero_r;
    if (fin) begin
      if (load_r || !dest_r) begin
        acc_nxt = mem_rdata;
      end
      zero_nxt = (mem_rdata == '0);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_r  <= `DMX_W_RESET;
      zero_r <= 1'b0;
    end else begin
      acc_r  <= acc_nxt;
      zero_r <= zero_nxt;
    end
  end

  // pointers step at issue, even for pre modes, so a back-to-back op sees the new value
  always_comb begin
    ptr0_nxt = ptr0_r;
    ptr1_nxt = ptr1_r;
    if (ind_go) begin
      if (op_ptr_sel) begin
        ptr1_nxt = ptr_after(ptr1_r, op_rel, pointer_update_mode);
      end else begin
        ptr0_nxt = ptr_after(ptr0_r, op_rel, pointer_update_mode);
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ptr0_r <= `DMX_PTR_RESET;
      ptr1_r <= `DMX_PTR_RESET;
    end else begin
      ptr0_r <= ptr0_nxt;
      ptr1_r <= ptr1_nxt;
    end
  end

  // the bank load has no path into the zero flag logic, so flags stay as they are
  always_comb begin
    bank_nxt = bank_r;
    if (bank_go) begin
      bank_nxt = op_literal;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bank_r <= `DMX_BANK_RESET;
    end else begin
      bank_r <= bank_nxt;
    end
  end

  // a write-back stays in the wait-free path, so a new op may be taken while it issues
  assign op_ready          = (state_r == DMX_IDLE);
  assign mem_rd            = rd_r;
  assign mem_wr            = wr_r;
  assign mem_addr          = addr_r;
  assign mem_wdata         = wdata_r;
  assign acc_w             = acc_r;
  assign zero_flag         = zero_r;
  assign bank_select_reg   = bank_r;
  assign indirect_pointer0 = ptr0_r;
  assign indirect_pointer1 = ptr1_r;
  assign op_done           = done_r;

endmodule : dmx_exec

// file: src/dmx_consts.svh
// constants for the data-move execution block
`ifndef DMX_CONSTS_SVH
`define DMX_CONSTS_SVH
`define DMX_DATA_W        8
`define DMX_PTR_W         16
`define DMX_FADDR_W       7
`define DMX_BANK_W        6
`define DMX_OFS_W         6
`define DMX_ALIAS0_ADDR   7'h00
`define DMX_ALIAS1_ADDR   7'h01
`define DMX_W_RESET       8'h00
`define DMX_PTR_RESET     16'h0000
`define DMX_BANK_RESET    6'h00
`define DMX_MODE_PREINC   2'h0
`define DMX_MODE_PREDEC   2'h1
`define DMX_MODE_POSTINC  2'h2
`define DMX_MODE_POSTDEC  2'h3
`endif

// file: src/dmx_pkg.sv
// types for the data-move execution block
package dmx_pkg;
  typedef enum logic [1:0] {
    DMX_OP_NONE,
    DMX_OP_FILE_MOVE,
    DMX_OP_INDIRECT_LOAD,
    DMX_OP_BANK_LOAD
  } dmx_op_type;
  typedef enum {
    DMX_IDLE,
    DMX_WAIT
  } dmx_state_type;
endpackage : dmx_pkg

// file: bench/dmx_exec_monitor.sv
// port assertions for the data-move block
`timescale 1ns/1ps
`include "dmx_consts.svh"
module dmx_exec_monitor
  import dmx_pkg::*;
#(parameter int DATA_W = 8, parameter int PTR_W = 16) (
  input wire logic clk, reset_n, op_valid, op_dest, op_ptr_sel, op_rel, op_ready, mem_rd, mem_wr,
  input wire dmx_op_type op_kind,
  input wire logic [`DMX_FADDR_W-1:0] op_faddr,
  input wire logic [1:0] pointer_update_mode,
  input wire logic [`DMX_OFS_W-1:0] op_offset,
  input wire logic [`DMX_BANK_W-1:0] op_literal, bank_select_reg,
  input wire logic [PTR_W-1:0] mem_addr, indirect_pointer0, indirect_pointer1,
  input wire logic [DATA_W-1:0] mem_wdata, mem_rdata, acc_w,
  input wire logic mem_rvalid, zero_flag, op_done
);
  logic [PTR_W-1:0] sp, ea, np, ap;
  dmx_op_type pk_r;
  logic pd_r;
  wire tk = op_valid && op_ready;
  wire dn = mem_rvalid && !op_ready;
  always_comb begin
    sp = op_ptr_sel ? indirect_pointer1 : indirect_pointer0;
    ap = op_faddr[0] ? indirect_pointer1 : indirect_pointer0;
    np = op_rel ? sp : (pointer_update_mode[0] ? sp - 1'b1 : sp + 1'b1);
    // post modes address the old pointer, pre modes the updated one
    ea = op_rel ? sp + {{(PTR_W-6){op_offset[5]}}, op_offset} : (pointer_update_mode[1] ? sp : np);
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pk_r <= DMX_OP_NONE;
      pd_r <= 1'b0;
    end else if (tk) begin
      pk_r <= op_kind;
      pd_r <= op_dest;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  bank_load_a: assert property (tk && op_kind == DMX_OP_BANK_LOAD |=> op_done
    && bank_select_reg == $past(op_literal) && $stable(zero_flag)) else $error("bank load wrong");
  ind_addr_a: assert property (tk && op_kind == DMX_OP_INDIRECT_LOAD |=> mem_rd
    && mem_addr == $past(ea)) else $error("indirect address wrong");
  ptr0_step_a: assert property (tk && op_kind == DMX_OP_INDIRECT_LOAD && !op_ptr_sel |=>
    indirect_pointer0 == $past(np) && $stable(indirect_pointer1)) else $error("pointer0 update wrong");
  ptr1_step_a: assert property (tk && op_kind == DMX_OP_INDIRECT_LOAD && op_ptr_sel |=>
    indirect_pointer1 == $past(np) && $stable(indirect_pointer0)) else $error("pointer1 update wrong");
  alias_read_a: assert property (tk && op_kind == DMX_OP_FILE_MOVE && op_faddr[6:1] == 6'h00 |=>
    mem_rd && mem_addr == $past(ap)) else $error("alias not redirected");
  ind_result_a: assert property (dn && pk_r == DMX_OP_INDIRECT_LOAD |=> op_done
    && acc_w == $past(mem_rdata) && zero_flag == ($past(mem_rdata) == '0)) else $error("indirect result wrong");
  move_acc_a: assert property (dn && pk_r == DMX_OP_FILE_MOVE && !pd_r |=> op_done && !mem_wr
    && acc_w == $past(mem_rdata) && zero_flag == ($past(mem_rdata) == '0)) else $error("move to acc wrong");
  move_back_a: assert property (dn && pk_r == DMX_OP_FILE_MOVE && pd_r |=> mem_wr && $stable(acc_w)
    && mem_wdata == $past(mem_rdata) && zero_flag == ($past(mem_rdata) == '0)) else $error("move back wrong");
endmodule : dmx_exec_monitor
bind dmx_exec dmx_exec_monitor #(.DATA_W(DATA_W), .PTR_W(PTR_W)) mon (.*);

// file: bench/tb_data_move_instruction_exec.sv
// self-checking bench for the data-move block
`timescale 1ns/1ps
`include "dmx_consts.svh"
module tb_data_move_instruction_exec
  import dmx_pkg::*;
;
  logic clk = 1'b0, reset_n = 1'b0, op_valid = 1'b0, op_dest = 1'b0, op_ptr_sel = 1'b0, op_rel = 1'b0;
  logic mem_rvalid = 1'b0, z = 1'b0;
  dmx_op_type op_kind = DMX_OP_NONE;
  logic [6:0] op_faddr = 7'h00;
  logic [1:0] pointer_update_mode = 2'h0;
  logic [5:0] op_offset = 6'h00, op_literal = 6'h00;
  logic [7:0] mem_rdata = 8'h00, acc = 8'h00, d;
  logic op_ready, mem_rd, mem_wr, zero_flag, op_done;
  logic [15:0] mem_addr, indirect_pointer0, indirect_pointer1, p[2];
  logic [7:0] mem_wdata, acc_w;
  logic [5:0] bank_select_reg;
  logic [31:0] r;
  int n_fail = 0, compares = 0, seed = 32'hc19dcacd;
  dmx_exec uut (.*);
  initial forever #12.5 clk = ~clk;
  // memory content is a pure function of address, so write-backs leave it unchanged
  function automatic logic [7:0] mem_val(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h10;
  endfunction : mem_val
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wrap_up;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up
  task automatic run(input dmx_op_type k, input logic [6:0] fa, input logic ds, ps, rl,
                     input logic [1:0] md, input logic [5:0] of, lt, input logic [1:0] lat);
    logic [15:0] a;
    @(posedge clk);
    op_valid <= 1'b1; op_kind <= k; op_faddr <= fa; op_dest <= ds; op_ptr_sel <= ps;
    op_rel <= rl; pointer_update_mode <= md; op_offset <= of; op_literal <= lt;
    @(posedge clk);
    op_valid <= 1'b0;
    #1;
    if (k == DMX_OP_BANK_LOAD) begin
      chk("bank", {10'h000, lt}, {10'h000, bank_select_reg});
      chk("bank_zero", {15'h0, z}, {15'h0, zero_flag});
    end else begin
      a = (fa[6:1] == 6'h00) ? p[fa[0]] : {9'h000, fa};
      if (k == DMX_OP_INDIRECT_LOAD) begin
        a = rl ? p[ps] + {{10{of[5]}}, of} : (md == 2'h0 ? p[ps] + 16'h1 : md == 2'h1 ? p[ps] - 16'h1 : p[ps]);
        p[ps] = rl ? p[ps] : (md[0] ? p[ps] - 16'h1 : p[ps] + 16'h1);
        chk("ptr", p[ps], ps ? indirect_pointer1 : indirect_pointer0);
      end
      chk("addr", a, mem_rd ? mem_addr : ~a);
      chk("busy", 16'h0, {15'h0, op_ready});
      d = mem_val(a);
      repeat (lat) @(posedge clk);
      @(posedge clk);
      mem_rvalid <= 1'b1; mem_rdata <= d;
      @(posedge clk);
      mem_rvalid <= 1'b0; mem_rdata <= ~d;
      #1;
      z = (d == 8'h00);
      if (!(k == DMX_OP_FILE_MOVE && ds)) acc = d;
      chk("acc", {8'h00, acc}, {8'h00, acc_w});
      chk("zero", {15'h0, z}, {15'h0, zero_flag});
      chk("wr", {15'h0, k == DMX_OP_FILE_MOVE && ds}, {15'h0, mem_wr});
      if (k == DMX_OP_FILE_MOVE && ds) chk("wdata", {8'h00, d}, {8'h00, mem_wdata});
    end
    chk("done", 16'h1, {15'h0, op_done});
    chk("ready", 16'h1, {15'h0, op_ready});
    $display("op %s ended", k.name());
  endtask : run
  initial begin
    p[0] = 16'h0000;
    p[1] = 16'h0000;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    run(DMX_OP_INDIRECT_LOAD, 7'h00, 1'b0, 1'b0, 1'b0, 2'h1, 6'h00, 6'h00, 2'h0);
    run(DMX_OP_INDIRECT_LOAD, 7'h00, 1'b0, 1'b0, 1'b0, 2'h0, 6'h00, 6'h00, 2'h1);
    run(DMX_OP_INDIRECT_LOAD, 7'h00, 1'b0, 1'b1, 1'b1, 2'h0, 6'h20, 6'h00, 2'h2);
    run(DMX_OP_INDIRECT_LOAD, 7'h00, 1'b0, 1'b1, 1'b1, 2'h3, 6'h1F, 6'h00, 2'h0);
    run(DMX_OP_FILE_MOVE, 7'h10, 1'b0, 1'b0, 1'b0, 2'h0, 6'h00, 6'h00, 2'h0);
    run(DMX_OP_FILE_MOVE, 7'h10, 1'b1, 1'b0, 1'b0, 2'h0, 6'h00, 6'h00, 2'h1);
    run(DMX_OP_FILE_MOVE, 7'h01, 1'b0, 1'b0, 1'b0, 2'h0, 6'h00, 6'h00, 2'h0);
    run(DMX_OP_BANK_LOAD, 7'h00, 1'b0, 1'b0, 1'b0, 2'h0, 6'h00, 6'h3F, 2'h0);
    repeat (60) begin
      r = $random(seed);
      run(dmx_op_type'(r[1:0] == 2'h0 ? 2'h2 : r[1:0]), r[8:2], r[9], r[10], r[11], r[13:12], r[19:14],
          r[25:20], r[27:26]);
    end
    wrap_up();
  end
endmodule : tb_data_move_instruction_exec
